//--- dspwm_defines.vh
// Purpose: constants for the dual-slope pwm timer
// Assumes: 16-bit counter, two compare channels
// Notes: mode codes follow the waveform mode select encoding
`ifndef DSPWM_DEFINES_VH
`define DSPWM_DEFINES_VH
`define DSPWM_W 16
`define DSPWM_MODE_PC8 4'h1
`define DSPWM_MODE_PC9 4'h2
`define DSPWM_MODE_PC10 4'h3
`define DSPWM_MODE_PFC_CAP 4'h8
`define DSPWM_MODE_PFC_CMPA 4'h9
`define DSPWM_MODE_PC_CAP 4'hA
`define DSPWM_MODE_PC_CMPA 4'hB
`define DSPWM_TOP8 16'h00FF
`define DSPWM_TOP9 16'h01FF
`define DSPWM_TOP10 16'h03FF
`define DSPWM_BOTTOM 16'h0000
`define DSPWM_COM_OFF 2'h0
`define DSPWM_COM_TOGGLE 2'h1
`define DSPWM_COM_NONINV 2'h2
`define DSPWM_COM_INV 2'h3
`define DSPWM_CMP_RESET 16'h0000
`define DSPWM_CAP_RESET 16'h0000
`endif

//--- dspwm_out_unit.v
// Purpose: one compare output waveform unit
// Assumes: match and direction come from the counter on the same clock
// Notes: toggle is only offered when the caller allows it
module dspwm_out_unit (
  input wire i_clk,
  input wire i_reset,
  input wire i_match,
  input wire i_counting_down,
  input wire [1:0] i_mode,
  input wire i_toggle_ok,
  input wire i_dir_out,
  output reg o_level,
  output reg o_pin,
  output reg o_pin_oe
);
`include "dspwm_defines.vh"

  reg level_d;

  always @*
  begin
    level_d = o_level;
    if (i_match)
    begin
      case (i_mode)
        `DSPWM_COM_TOGGLE: if (i_toggle_ok) level_d = ~o_level;
        `DSPWM_COM_NONINV: level_d = i_counting_down;
        `DSPWM_COM_INV: level_d = ~i_counting_down;
        default: level_d = o_level;
      endcase
    end
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_level <= 1'b0;
      o_pin <= 1'b0;
      o_pin_oe <= 1'b0;
    end
    else
    begin
      o_level <= level_d;
      o_pin <= level_d;
      // pin only driven when connected and direction is output
      o_pin_oe <= i_dir_out && (i_mode[1] || (i_mode[0] && i_toggle_ok));
    end
  end
endmodule

//--- dspwm_timer.v
// Purpose: dual-slope pwm timer core, phase correct and phase and frequency correct
// Assumes: prescaler supplies a one-cycle timer clock enable on the I/O clock
// Notes: other waveform modes leave the counter and the flags frozen
// Behaviour
// - modes 1, 2, 3, 10, 11 run phase correct pwm.
// - counter counts up from zero to top, then down to zero, repeatedly.
// - non-inverting clears on up-match, sets on down-match; inverting reversed.
// - output mode two is non-inverted pwm, three is inverted pwm.
// - top is 0x00FF, 0x01FF, 0x03FF, capture value, or compare a value.
// - counter holds top for exactly one timer clock before counting down.
// - phase correct sets overflow flag each time counter reaches zero.
// - phase correct loads compare buffers at top, flagging compare a or capture.
// - channel compare flag sets whenever counter equals its compare value.
// - fixed top modes mask compare writes above the resolution to zero.
// - compare zero gives constant low, compare top constant high, non-inverted.
// - mode 11 with output mode 1 toggles output a, 50% duty.
// - modes 8 (capture top) and 9 (compare a top) are phase and frequency correct.
// - phase and frequency correct loads buffers at zero, setting overflow then.
// - phase and frequency correct sets compare a or capture flag at top.
// - mode 9 with output mode 1 toggles output a, 50% duty.
// - output reaches pin only when its direction bit selects output.
// - phase correct periods start and end at top.
// - output frequency is I/O clock over twice prescale times top.
// - compare a writes go to a buffer, active only at update point.
// - capture value is unbuffered, taking effect at once.
// - output mode 1 toggles a only in modes 9, 11; else disconnected.
module dspwm_timer (
  input wire I_CLK_SYS,
  input wire I_RESET,
  input wire I_TIMER_CLK_EN,
  input wire [3:0] I_WAVEFORM_MODE_SELECT,
  input wire [1:0] I_COMPARE_OUTPUT_MODE_A,
  input wire [1:0] I_COMPARE_OUTPUT_MODE_B,
  input wire I_OUTPUT_DIRECTION_BIT_A,
  input wire I_OUTPUT_DIRECTION_BIT_B,
  input wire I_COMPARE_VALUE_A_WR,
  input wire I_COMPARE_VALUE_B_WR,
  input wire I_CAPTURE_VALUE_WR,
  input wire [15:0] I_WR_DATA,
  input wire I_FLAG_CLEAR_OVERFLOW,
  input wire I_FLAG_CLEAR_COMPARE_A,
  input wire I_FLAG_CLEAR_COMPARE_B,
  input wire I_FLAG_CLEAR_CAPTURE,
  output reg [15:0] O_COUNTER_VALUE,
  output reg [15:0] O_COMPARE_VALUE_A,
  output reg [15:0] O_COMPARE_VALUE_B,
  output reg [15:0] O_CAPTURE_VALUE,
  output reg O_COUNTING_DOWN,
  output reg O_OVERFLOW_FLAG,
  output reg O_COMPARE_FLAG_A,
  output reg O_COMPARE_FLAG_B,
  output reg O_CAPTURE_FLAG,
  output wire O_COMPARE_OUTPUT_A,
  output wire O_COMPARE_OUTPUT_A_OE,
  output wire O_COMPARE_OUTPUT_B,
  output wire O_COMPARE_OUTPUT_B_OE
);
`include "dspwm_defines.vh"

  reg [15:0] buf_a_q;
  reg [15:0] buf_b_q;
  reg [15:0] top;
  reg phase_correct;
  reg freq_correct;
  reg top_is_cmpa;
  reg top_is_cap;
  reg [15:0] mask;
  reg [15:0] cnt_d;
  reg down_d;
  reg at_top;
  reg at_bottom;
  reg update_now;
  reg match_a;
  reg match_b;
  reg dual_slope;
  reg eff_down;
  reg set_ovf;
  reg set_cmp_a;
  reg set_cmp_b;
  reg set_cap;
  wire toggle_ok;

  // equality of counter and a compare value, only while a dual-slope mode runs
  function compare_hit;
    input [15:0] count;
    input [15:0] value;
    input running;
    begin
      compare_hit = running && (count == value);
    end
  endfunction

  // one count step in the given direction, wrapping at the 16-bit limit
  function [15:0] step_count;
    input [15:0] value;
    input down;
    begin
      if (down)
        step_count = value - 16'h0001;
      else
        step_count = value + 16'h0001;
    end
  endfunction

  // a set in the same cycle as a clear wins
  function flag_next;
    input current;
    input set_in;
    input clear_in;
    begin
      if (set_in)
        flag_next = 1'b1;
      else if (clear_in)
        flag_next = 1'b0;
      else
        flag_next = current;
    end
  endfunction

  // top and resolution mask for the selected mode
  always @*
  begin
    phase_correct = 1'b0;
    freq_correct = 1'b0;
    top_is_cmpa = 1'b0;
    top_is_cap = 1'b0;
    top = `DSPWM_TOP8;
    mask = 16'hFFFF;
    case (I_WAVEFORM_MODE_SELECT)
      `DSPWM_MODE_PC8:
      begin
        phase_correct = 1'b1;
        top = `DSPWM_TOP8;
        mask = `DSPWM_TOP8;
      end
      `DSPWM_MODE_PC9:
      begin
        phase_correct = 1'b1;
        top = `DSPWM_TOP9;
        mask = `DSPWM_TOP9;
      end
      `DSPWM_MODE_PC10:
      begin
        phase_correct = 1'b1;
        top = `DSPWM_TOP10;
        mask = `DSPWM_TOP10;
      end
      // unbuffered capture written below the counter makes it miss top
      `DSPWM_MODE_PC_CAP:
      begin
        phase_correct = 1'b1;
        top_is_cap = 1'b1;
        top = O_CAPTURE_VALUE;
      end
      `DSPWM_MODE_PC_CMPA:
      begin
        phase_correct = 1'b1;
        top_is_cmpa = 1'b1;
        top = O_COMPARE_VALUE_A;
      end
      `DSPWM_MODE_PFC_CAP:
      begin
        freq_correct = 1'b1;
        top_is_cap = 1'b1;
        top = O_CAPTURE_VALUE;
      end
      `DSPWM_MODE_PFC_CMPA:
      begin
        freq_correct = 1'b1;
        top_is_cmpa = 1'b1;
        top = O_COMPARE_VALUE_A;
      end
      default:
      begin
        top = `DSPWM_TOP8;
      end
    endcase
    dual_slope = phase_correct || freq_correct;
  end

  // toggle only where compare a is itself top
  assign toggle_ok = top_is_cmpa;

  // counter sequence; top held one tick, reversal decided there
  always @*
  begin
    at_top = (O_COUNTER_VALUE == top);
    at_bottom = (O_COUNTER_VALUE == `DSPWM_BOTTOM);
    cnt_d = O_COUNTER_VALUE;
    down_d = O_COUNTING_DOWN;
    if (dual_slope && I_TIMER_CLK_EN)
    begin
      if (at_top && !O_COUNTING_DOWN)
      begin
        down_d = 1'b1;
        cnt_d = step_count(O_COUNTER_VALUE, 1'b1);
      end
      else if (at_bottom && O_COUNTING_DOWN)
      begin
        down_d = 1'b0;
        cnt_d = 16'h0001;
      end
      else
        cnt_d = step_count(O_COUNTER_VALUE, O_COUNTING_DOWN);
    end
  end

  // events are judged in the tick where the counter shows the value
  always @*
  begin
    update_now = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    set_ovf = 1'b0;
    set_cmp_a = 1'b0;
    set_cap = 1'b0;
    if (I_TIMER_CLK_EN)
    begin
      update_now = (phase_correct && at_top) || (freq_correct && at_bottom);
      match_a = compare_hit(O_COUNTER_VALUE, O_COMPARE_VALUE_A, dual_slope);
      match_b = compare_hit(O_COUNTER_VALUE, O_COMPARE_VALUE_B, dual_slope);
      set_ovf = dual_slope && at_bottom;
      set_cmp_a = match_a || (at_top && top_is_cmpa);
      set_cap = at_top && top_is_cap && dual_slope;
    end
    set_cmp_b = match_b;
    // a match at top acts as down-counting and one at bottom as up-counting,
    // so compare equal top stays high and compare zero stays low
    eff_down = O_COUNTING_DOWN;
    if (at_top)
      eff_down = 1'b1;
    else if (at_bottom)
      eff_down = 1'b0;
  end

  always @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      O_COUNTER_VALUE <= `DSPWM_BOTTOM;
      O_COUNTING_DOWN <= 1'b0;
      buf_a_q <= `DSPWM_CMP_RESET;
      buf_b_q <= `DSPWM_CMP_RESET;
      O_COMPARE_VALUE_A <= `DSPWM_CMP_RESET;
      O_COMPARE_VALUE_B <= `DSPWM_CMP_RESET;
      O_CAPTURE_VALUE <= `DSPWM_CAP_RESET;
      O_OVERFLOW_FLAG <= 1'b0;
      O_COMPARE_FLAG_A <= 1'b0;
      O_COMPARE_FLAG_B <= 1'b0;
      O_CAPTURE_FLAG <= 1'b0;
    end
    else
    begin
      O_COUNTER_VALUE <= cnt_d;
      O_COUNTING_DOWN <= down_d;
      if (I_COMPARE_VALUE_A_WR)
        buf_a_q <= I_WR_DATA & mask;
      if (I_COMPARE_VALUE_B_WR)
        buf_b_q <= I_WR_DATA & mask;
      if (I_CAPTURE_VALUE_WR)
        O_CAPTURE_VALUE <= I_WR_DATA;
      if (update_now)
      begin
        O_COMPARE_VALUE_A <= buf_a_q;
        O_COMPARE_VALUE_B <= buf_b_q;
      end
      O_OVERFLOW_FLAG <= flag_next(O_OVERFLOW_FLAG, set_ovf, I_FLAG_CLEAR_OVERFLOW);
      O_COMPARE_FLAG_A <= flag_next(O_COMPARE_FLAG_A, set_cmp_a, I_FLAG_CLEAR_COMPARE_A);
      O_COMPARE_FLAG_B <= flag_next(O_COMPARE_FLAG_B, set_cmp_b, I_FLAG_CLEAR_COMPARE_B);
      O_CAPTURE_FLAG <= flag_next(O_CAPTURE_FLAG, set_cap, I_FLAG_CLEAR_CAPTURE);
    end
  end

  dspwm_out_unit u_out_a (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_match(match_a),
    .i_counting_down(eff_down),
    .i_mode(I_COMPARE_OUTPUT_MODE_A),
    .i_toggle_ok(toggle_ok),
    .i_dir_out(I_OUTPUT_DIRECTION_BIT_A),
    .o_level(),
    .o_pin(O_COMPARE_OUTPUT_A),
    .o_pin_oe(O_COMPARE_OUTPUT_A_OE)
  );

  // toggle is never offered on channel b
  dspwm_out_unit u_out_b (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .i_match(match_b),
    .i_counting_down(eff_down),
    .i_mode(I_COMPARE_OUTPUT_MODE_B),
    .i_toggle_ok(1'b0),
    .i_dir_out(I_OUTPUT_DIRECTION_BIT_B),
    .o_level(),
    .o_pin(O_COMPARE_OUTPUT_B),
    .o_pin_oe(O_COMPARE_OUTPUT_B_OE)
  );
endmodule

//--- dspwm_properties.sv
// Purpose: port checker for dspwm_timer
// Assumes: one clock, sync reset
// Notes: waveform checks use the 8-bit mode
module dspwm_properties (
  input wire I_CLK_SYS,
  input wire I_RESET,
  input wire I_TIMER_CLK_EN,
  input wire [3:0] I_WAVEFORM_MODE_SELECT,
  input wire [1:0] I_COMPARE_OUTPUT_MODE_A,
  input wire [1:0] I_COMPARE_OUTPUT_MODE_B,
  input wire I_OUTPUT_DIRECTION_BIT_A,
  input wire [15:0] O_COUNTER_VALUE,
  input wire [15:0] O_COMPARE_VALUE_A,
  input wire [15:0] O_COMPARE_VALUE_B,
  input wire O_COUNTING_DOWN,
  input wire O_OVERFLOW_FLAG,
  input wire O_COMPARE_FLAG_B,
  input wire O_COMPARE_OUTPUT_A,
  input wire O_COMPARE_OUTPUT_A_OE,
  input wire O_COMPARE_OUTPUT_B_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [3:0] md = I_WAVEFORM_MODE_SELECT;
  wire m1 = I_TIMER_CLK_EN && md == 4'h1;
  wire [15:0] c = O_COUNTER_VALUE;
  wire [15:0] ca = O_COMPARE_VALUE_A;
  wire tg = md == 4'h9 || md == 4'hB;
  // matches at 0 and top skipped, direction is ambiguous there
  wire mid = m1 && I_COMPARE_OUTPUT_MODE_A == 2'h2 && I_OUTPUT_DIRECTION_BIT_A && c == ca
    && ca != 16'h0000 && ca != 16'h00FF;
  default clocking @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);
  tick_gate_a: assert property (!I_TIMER_CLK_EN |=> $stable(c))
    else $error("counter moved without tick");
  up_step_a: assert property (m1 && !O_COUNTING_DOWN && c != 16'h0000 && c < 16'h00FF
    |=> c == $past(c) + 16'h0001) else $error("up step wrong");
  top_hold_a: assert property (m1 && c == 16'h00FF |=> c == 16'h00FE)
    else $error("top not held one tick");
  bottom_ovf_a: assert property (m1 && c == 16'h0000 |=> O_OVERFLOW_FLAG)
    else $error("overflow flag missing");
  up_clear_a: assert property (mid && !O_COUNTING_DOWN |=> !O_COMPARE_OUTPUT_A)
    else $error("up match did not clear");
  down_set_a: assert property (mid && O_COUNTING_DOWN |=> O_COMPARE_OUTPUT_A)
    else $error("down match did not set");
  flag_b_a: assert property (m1 && c == O_COMPARE_VALUE_B |=> O_COMPARE_FLAG_B)
    else $error("compare flag b missing");
  toggle_gate_a: assert property ((I_COMPARE_OUTPUT_MODE_A == 2'h1 && !tg) [*2] |-> !O_COMPARE_OUTPUT_A_OE)
    else $error("toggle a connected");
  b_toggle_a: assert property ((I_COMPARE_OUTPUT_MODE_B == 2'h1) [*2] |-> !O_COMPARE_OUTPUT_B_OE)
    else $error("toggle b connected");
  dir_gate_a: assert property ((!I_OUTPUT_DIRECTION_BIT_A) [*2] |-> !O_COMPARE_OUTPUT_A_OE)
    else $error("pin a driven as input");
  top_high_a: assert property (m1 && I_COMPARE_OUTPUT_MODE_A == 2'h2 && c == 16'h00FF
    && ca == 16'h00FF |=> O_COMPARE_OUTPUT_A) else $error("compare at top not high");
  cover property (m1 && c == 16'h00FF);
  cover property (mid && O_COUNTING_DOWN);
  cover property (I_TIMER_CLK_EN && tg && c == ca);
endmodule
bind dspwm_timer dspwm_properties u_checks (
  .I_CLK_SYS(I_CLK_SYS),
  .I_RESET(I_RESET),
  .I_TIMER_CLK_EN(I_TIMER_CLK_EN),
  .I_WAVEFORM_MODE_SELECT(I_WAVEFORM_MODE_SELECT),
  .I_COMPARE_OUTPUT_MODE_A(I_COMPARE_OUTPUT_MODE_A),
  .I_COMPARE_OUTPUT_MODE_B(I_COMPARE_OUTPUT_MODE_B),
  .I_OUTPUT_DIRECTION_BIT_A(I_OUTPUT_DIRECTION_BIT_A),
  .O_COUNTER_VALUE(O_COUNTER_VALUE),
  .O_COMPARE_VALUE_A(O_COMPARE_VALUE_A),
  .O_COMPARE_VALUE_B(O_COMPARE_VALUE_B),
  .O_COUNTING_DOWN(O_COUNTING_DOWN),
  .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG),
  .O_COMPARE_FLAG_B(O_COMPARE_FLAG_B),
  .O_COMPARE_OUTPUT_A(O_COMPARE_OUTPUT_A),
  .O_COMPARE_OUTPUT_A_OE(O_COMPARE_OUTPUT_A_OE),
  .O_COMPARE_OUTPUT_B_OE(O_COMPARE_OUTPUT_B_OE)
);

//--- dspwm_load.sv
// Purpose: pulled-down load on both compare pads
// Assumes: a released pad falls low
// Notes: behavioural only
module dspwm_load (
  input wire i_pin_a,
  input wire i_oe_a,
  input wire i_pin_b,
  input wire i_oe_b,
  output wire o_pad_a,
  output wire o_pad_b
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_pad_a = i_oe_a ? i_pin_a : 1'b0;
  assign o_pad_b = i_oe_b ? i_pin_b : 1'b0;
endmodule

//--- dspwm_timer_bench.sv
// Purpose: self-checking bench for dspwm_timer
// Assumes: tick held high, one timer clock per cycle
// Notes: duty counted on the pads
module dspwm_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk = 0, rst = 1, tk = 0, wa = 0, wb = 0, wc = 0, cl = 0, da = 1, db = 1;
  reg [3:0] md = 4'h0;
  reg [1:0] ma = 2'h0, mb = 2'h0;
  reg [15:0] wd = 16'h0000;
  wire [15:0] cnt, cva, cvb, cap;
  wire dn, ovf, fa, fb, fc, oa, oea, ob, oeb, pa, pb;
  integer err_total = 0, checked = 0;
  dspwm_timer dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_TIMER_CLK_EN(tk), .I_WAVEFORM_MODE_SELECT(md),
    .I_COMPARE_OUTPUT_MODE_A(ma), .I_COMPARE_OUTPUT_MODE_B(mb), .I_OUTPUT_DIRECTION_BIT_A(da),
    .I_OUTPUT_DIRECTION_BIT_B(db), .I_COMPARE_VALUE_A_WR(wa), .I_COMPARE_VALUE_B_WR(wb),
    .I_CAPTURE_VALUE_WR(wc), .I_WR_DATA(wd), .I_FLAG_CLEAR_OVERFLOW(cl), .I_FLAG_CLEAR_COMPARE_A(cl),
    .I_FLAG_CLEAR_COMPARE_B(cl), .I_FLAG_CLEAR_CAPTURE(cl), .O_COUNTER_VALUE(cnt),
    .O_COMPARE_VALUE_A(cva), .O_COMPARE_VALUE_B(cvb), .O_CAPTURE_VALUE(cap), .O_COUNTING_DOWN(dn),
    .O_OVERFLOW_FLAG(ovf), .O_COMPARE_FLAG_A(fa), .O_COMPARE_FLAG_B(fb), .O_CAPTURE_FLAG(fc),
    .O_COMPARE_OUTPUT_A(oa), .O_COMPARE_OUTPUT_A_OE(oea), .O_COMPARE_OUTPUT_B(ob),
    .O_COMPARE_OUTPUT_B_OE(oeb));
  dspwm_load ld (.i_pin_a(oa), .i_oe_a(oea), .i_pin_b(ob), .i_oe_b(oeb), .o_pad_a(pa), .o_pad_b(pb));
  initial forever #50 clk = ~clk;
  task chk(input [15:0] e, input [15:0] s, input [8*8:1] n);
    begin
      checked = checked + 1;
      if (s !== e)
      begin
        err_total = err_total + 1;
        $display("mismatch %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  // strobes rise and fall at falling edges, one idle edge between writes
  task wr(input [1:0] w, input [15:0] d);
    begin
      wd = d;
      wa = w == 2'h0;
      wb = w == 2'h1;
      wc = w == 2'h2;
      @(negedge clk);
      {wa, wb, wc} = 3'h0;
      @(negedge clk);
    end
  endtask
  task clr;
    begin
      cl = 1;
      @(negedge clk);
      cl = 0;
    end
  endtask
  task wcnt(input [15:0] v);
    integer i;
    begin
      for (i = 0; cnt !== v && i < 3000; i = i + 1)
        @(negedge clk);
      chk(v, cnt, "counter");
    end
  endtask
  task duty(input integer n, input [15:0] ea, input [15:0] eb);
    integer i, ha, hb;
    begin
      ha = 0;
      hb = 0;
      for (i = 0; i < n; i = i + 1)
      begin
        ha = ha + (pa === 1'b1);
        hb = hb + (pb === 1'b1);
        @(negedge clk);
      end
      chk(ea, ha[15:0], "duty a");
      chk(eb, hb[15:0], "duty b");
    end
  endtask
  task t_pc8;
    begin
      md = 4'h1;
      ma = 2'h1;
      mb = 2'h3;
      tk = 1;
      wr(2'h0, 16'h1234);
      wr(2'h1, 16'h0234);
      chk(16'h0000, cva, "buffer");
      ma = 2'h2;
      wcnt(16'h00FF);
      @(negedge clk);
      chk(16'h0034, cva, "mask a");
      chk(16'h0034, cvb, "mask b");
      wcnt(16'h00FF);
      clr;
      duty(510, 16'd104, 16'd406);
      chk(16'h0007, {ovf, fa, fb}, "flags");
      wr(2'h0, 16'h00FF);
      wr(2'h1, 16'h0000);
      ma = 2'h2;
      wcnt(16'h00FF);
      @(negedge clk);
      wcnt(16'h00FF);
      @(negedge clk);
      duty(510, 16'd510, 16'd510);
    end
  endtask
  // toggle a only; b must stay released
  task t_tog(input [3:0] m);
    begin
      md = m;
      ma = 2'h1;
      mb = 2'h1;
      wr(2'h0, 16'h0005);
      wcnt(16'h0000);
      wcnt(16'h0005);
      wcnt(16'h0000);
      wcnt(16'h0005);
      clr;
      chk(16'h0004, cnt, "counter");
      duty(20, 16'd10, 16'd0);
      chk(16'h0003, {ovf, fa}, "flags");
    end
  endtask
  task t_cap;
    begin
      md = 4'hA;
      wr(2'h2, 16'h0007);
      chk(16'h0007, cap, "capture");
      wcnt(16'h0007);
      clr;
      chk(16'h0006, cnt, "counter");
      chk(16'h0001, {ovf, fc}, "flags");
      ma = 2'h2;
      da = 0;
      repeat (2) @(negedge clk);
      chk(16'h0000, {oea, pa}, "pad");
    end
  endtask
  // fixed 10-bit top, then capture top in phase and frequency correct mode
  task t_wide;
    begin
      md = 4'h3;
      wr(2'h1, 16'hFFFF);
      wcnt(16'h03FF);
      @(negedge clk);
      chk(16'h03FF, cvb, "mask 10");
      wr(2'h0, 16'h0001);
      wr(2'h1, 16'h0002);
      wr(2'h2, 16'h0003);
      wcnt(16'h0000);
      md = 4'h8;
      wcnt(16'h0003);
      clr;
      chk(16'h0002, cvb, "pfc load");
      chk(16'h0002, cnt, "counter");
      chk(16'h0001, {ovf, fc}, "flags");
    end
  endtask
  task give_verdict;
    begin
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 0;
    chk(16'h0000, cnt, "counter");
    t_pc8;
    t_tog(4'h9);
    t_tog(4'hB);
    t_cap;
    t_wide;
    give_verdict;
  end
  initial
  begin
    #2000000;
    err_total = err_total + 1;
    give_verdict;
  end
endmodule
